// ### pkg/tmr_pkg.sv
// package: register map, field positions and modes of the capture/compare timer
// Function
// - one shared interrupt from enabled flags, mask clear
// - enabled events wake from wait, never halt
// - capture enable gates both capture flags
// - compare enable gates both compare flags
// - overflow enable gates overflow flag
// - force bit two copies level two
// - force bit one copies level one
// - match two drives level two
// - per-capture edge select, one means rising
// - match one drives level one on pin
// - pin enables gate pins only, not flags
// - one-pulse mode triggered by capture one edge
// - pwm mode: value one width, two period
// - clock select: div4, div2, div8, external
// - no external pin: external select stops counter
// - external edge select, one means rising
// - capture one flag set, two-step clear
// - compare flags set on match (neither in pwm, only two in one-pulse), two-step clear
// - overflow flag on wrap, main low clears
// - capture two flag set, two-step clear
// - status low three bits read zero
// - capture one latches counter into two bytes
// - pwm period match reloads counter to FFFC
package tmr_pkg;
	localparam logic [4:0] A_CTRL_TWO   = 5'h01;
	localparam logic [4:0] A_CTRL_ONE   = 5'h02;
	localparam logic [4:0] A_STATUS     = 5'h03;
	localparam logic [4:0] A_CAP1_HI    = 5'h04;
	localparam logic [4:0] A_CAP1_LO    = 5'h05;
	localparam logic [4:0] A_CMP1_HI    = 5'h06;
	localparam logic [4:0] A_CMP1_LO    = 5'h07;
	localparam logic [4:0] A_CNT_HI     = 5'h08;
	localparam logic [4:0] A_CNT_LO     = 5'h09;
	localparam logic [4:0] A_ACNT_HI    = 5'h0A;
	localparam logic [4:0] A_ACNT_LO    = 5'h0B;
	localparam logic [4:0] A_CAP2_HI    = 5'h0C;
	localparam logic [4:0] A_CAP2_LO    = 5'h0D;
	localparam logic [4:0] A_CMP2_HI    = 5'h0E;
	localparam logic [4:0] A_CMP2_LO    = 5'h0F;
	localparam logic [15:0] CNT_RESET   = 16'hFFFC;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CMP_RESET   = 16'h8000;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [1:0]  CLK_DIV4    = 2'b00;
	localparam logic [1:0]  CLK_DIV2    = 2'b01;
	localparam logic [1:0]  CLK_DIV8    = 2'b10;
	localparam logic [1:0]  CLK_EXT     = 2'b11;
	localparam logic [2:0]  PRE_MASK2   = 3'h1;
	localparam logic [2:0]  PRE_MASK4   = 3'h3;
	localparam logic [2:0]  PRE_MASK8   = 3'h7;
	typedef struct packed {
		logic       capture_irq_enable;
		logic       compare_irq_enable;
		logic       overflow_irq_enable;
		logic       force_compare_two;
		logic       force_compare_one;
		logic       output_level_two;
		logic       capture_one_edge_select;
		logic       output_level_one;
	} ctrl_one_s;
	typedef struct packed {
		logic       compare_one_pin_enable;
		logic       compare_two_pin_enable;
		logic       one_pulse_mode_enable;
		logic       pwm_mode_enable;
		logic [1:0] timer_clock_select;
		logic       capture_two_edge_select;
		logic       ext_clock_edge_select;
	} ctrl_two_s;
	typedef struct packed {
		logic       capture_one_flag;
		logic       compare_one_flag;
		logic       overflow_flag;
		logic       capture_two_flag;
		logic       compare_two_flag;
		logic [2:0] unused;
	} status_s;
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;
endpackage : tmr_pkg

// ### design/timer16_capture_compare_ctrl.sv
// 16-bit free-running timer with two captures, two compares, pwm and one-pulse
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module timer16_capture_compare_ctrl
	import tmr_pkg::*;
#(
	parameter bit HAS_EXT_CLK = 1'b1
)(
	input  wire logic     clk_sys,
	input  wire logic     nrst,
	input  wire bus_req_s bus_req,
	output logic [7:0]    rdata,
	input  wire logic     cpu_irq_mask,
	input  wire logic     in_wait_mode,
	input  wire logic     in_halt_mode,
	input  wire logic     capture_one_pin,
	input  wire logic     capture_two_pin,
	input  wire logic     external_count_clock_pin,
	output logic          compare_one_pin,
	output logic          compare_one_pin_oe,
	output logic          compare_two_pin,
	output logic          compare_two_pin_oe,
	output logic          timer_irq,
	output logic          wait_wakeup
);
	ctrl_one_s   c1_q;
	ctrl_two_s   c2_q;
	logic [15:0] cnt_q;
	logic [15:0] cmp1_q;
	logic [15:0] cmp2_q;
	logic [15:0] cap1_q;
	logic [15:0] cap2_q;
	logic [2:0]  pre_q;
	logic        cap1_in_q;
	logic        cap2_in_q;
	logic        ext_in_q;
	logic        st_read_q;
	logic        cmp1_hold_q;
	logic        cmp2_hold_q;
	logic        f_cap1_q;
	logic        f_cap2_q;
	logic        f_cmp1_q;
	logic        f_cmp2_q;
	logic        f_ovf_q;
	logic        pin1_q;
	logic        pin2_q;
	logic        pulse_run_q;
	logic [7:0]  rdata_q;
	logic [2:0]  pre_mask;
	logic        tick;
	logic        pwm_on;
	logic        opm_on;
	logic        cap1_edge;
	logic        cap2_edge;
	logic        ext_edge;
	logic        match1;
	logic        match2;
	logic        cnt_reload;
	logic        irq_src;
	status_s     st;

	wire acc_any = bus_req.wr | bus_req.rd;
	wire wr_cnt  = bus_req.wr && (bus_req.addr == A_CNT_LO || bus_req.addr == A_ACNT_LO);

	// only rising/falling transitions chosen by the edge bits count
	assign cap1_edge = c1_q.capture_one_edge_select ? (capture_one_pin & ~cap1_in_q)
		: (~capture_one_pin & cap1_in_q);
	assign cap2_edge = c2_q.capture_two_edge_select ? (capture_two_pin & ~cap2_in_q)
		: (~capture_two_pin & cap2_in_q);
	assign ext_edge  = c2_q.ext_clock_edge_select ? (external_count_clock_pin & ~ext_in_q)
		: (~external_count_clock_pin & ext_in_q);
	assign pwm_on    = c2_q.pwm_mode_enable;
	assign opm_on    = c2_q.one_pulse_mode_enable & ~pwm_on;

	always_comb
	begin
		case (c2_q.timer_clock_select)
			CLK_DIV2: pre_mask = PRE_MASK2;
			CLK_DIV4: pre_mask = PRE_MASK4;
			CLK_DIV8: pre_mask = PRE_MASK8;
			default:  pre_mask = PRE_MASK4;
		endcase
	end

	// halt freezes counting; external select with no pin never ticks
	always_comb
	begin
		if (in_halt_mode)
			tick = 1'b0;
		else if (c2_q.timer_clock_select == CLK_EXT)
			tick = HAS_EXT_CLK & ext_edge;
		else
			tick = (pre_q & pre_mask) == pre_mask;
	end

	// a write to the high compare byte inhibits matching until the low byte
	assign match1 = tick && !cmp1_hold_q && cnt_q == cmp1_q;
	assign match2 = tick && !cmp2_hold_q && cnt_q == cmp2_q;
	assign cnt_reload = (pwm_on && match2) || (opm_on && cap1_edge);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cap1_in_q <= 1'b0;
			cap2_in_q <= 1'b0;
			ext_in_q  <= 1'b0;
		end
		else
		begin
			cap1_in_q <= capture_one_pin;
			cap2_in_q <= capture_two_pin;
			ext_in_q  <= external_count_clock_pin;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			pre_q <= 3'h0;
		else
			pre_q <= pre_q + 3'h1;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= CNT_RESET;
		else if (cnt_reload || wr_cnt)
			cnt_q <= CNT_RESET;
		else if (tick)
			cnt_q <= cnt_q + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			c1_q        <= ctrl_one_s'(CTRL_RESET);
			c2_q        <= ctrl_two_s'(CTRL_RESET);
			cmp1_q      <= CMP_RESET;
			cmp2_q      <= CMP_RESET;
			cmp1_hold_q <= 1'b0;
			cmp2_hold_q <= 1'b0;
		end
		else if (bus_req.wr)
		begin
			case (bus_req.addr)
				A_CTRL_ONE: c1_q <= ctrl_one_s'(bus_req.wdata);
				A_CTRL_TWO: c2_q <= ctrl_two_s'(bus_req.wdata);
				A_CMP1_HI:
				begin
					cmp1_q[15:8] <= bus_req.wdata;
					cmp1_hold_q  <= 1'b1;
				end
				A_CMP1_LO:
				begin
					cmp1_q[7:0] <= bus_req.wdata;
					cmp1_hold_q <= 1'b0;
				end
				A_CMP2_HI:
				begin
					cmp2_q[15:8] <= bus_req.wdata;
					cmp2_hold_q  <= 1'b1;
				end
				A_CMP2_LO:
				begin
					cmp2_q[7:0] <= bus_req.wdata;
					cmp2_hold_q <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// capture registers have no reset value by design
	always_ff @(posedge clk_sys)
	begin
		if (cap1_edge && !pwm_on && !opm_on)
			cap1_q <= cnt_q;
		if (cap2_edge)
			cap2_q <= cnt_q;
	end

	// status read arms the clear; the very next access completes it if it is to that flag's low byte
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			st_read_q <= 1'b0;
		else if (bus_req.rd && bus_req.addr == A_STATUS)
			st_read_q <= 1'b1;
		else if (acc_any)
			st_read_q <= 1'b0;
	end

	// set wins over the two-step clear in the same cycle
	wire clr_ok = st_read_q && acc_any;
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			f_cap1_q <= 1'b0;
			f_cap2_q <= 1'b0;
			f_cmp1_q <= 1'b0;
			f_cmp2_q <= 1'b0;
			f_ovf_q  <= 1'b0;
		end
		else
		begin
			if ((cap1_edge && !pwm_on) || (pwm_on && match2))
				f_cap1_q <= 1'b1;
			else if (clr_ok && bus_req.addr == A_CAP1_LO)
				f_cap1_q <= 1'b0;
			if (cap2_edge)
				f_cap2_q <= 1'b1;
			else if (clr_ok && bus_req.addr == A_CAP2_LO)
				f_cap2_q <= 1'b0;
			if (match1 && !pwm_on && !opm_on)
				f_cmp1_q <= 1'b1;
			else if (clr_ok && bus_req.addr == A_CMP1_LO)
				f_cmp1_q <= 1'b0;
			if (match2 && !pwm_on)
				f_cmp2_q <= 1'b1;
			else if (clr_ok && bus_req.addr == A_CMP2_LO)
				f_cmp2_q <= 1'b0;
			if (tick && cnt_q == CNT_MAX && !cnt_reload && !wr_cnt)
				f_ovf_q <= 1'b1;
			else if (clr_ok && bus_req.addr == A_CNT_LO)
				f_ovf_q <= 1'b0;
		end
	end

	// pin levels; pulse modes steer both levels onto pin one
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pin1_q      <= 1'b0;
			pin2_q      <= 1'b0;
			pulse_run_q <= 1'b0;
		end
		else
		begin
			if (pwm_on)
			begin
				if (match2)
					pin1_q <= c1_q.output_level_two;
				else if (match1)
					pin1_q <= c1_q.output_level_one;
			end
			else if (opm_on)
			begin
				if (cap1_edge)
				begin
					pin1_q      <= c1_q.output_level_two;
					pulse_run_q <= 1'b1;
				end
				else if (match1 && pulse_run_q)
				begin
					pin1_q      <= c1_q.output_level_one;
					pulse_run_q <= 1'b0;
				end
			end
			else if (match1 || c1_q.force_compare_one)
				pin1_q <= c1_q.output_level_one;
			if (!pwm_on && !opm_on && (match2 || c1_q.force_compare_two))
				pin2_q <= c1_q.output_level_two;
		end
	end

	assign compare_one_pin    = pin1_q;
	assign compare_two_pin    = pin2_q;
	assign compare_one_pin_oe = c2_q.compare_one_pin_enable;
	assign compare_two_pin_oe = c2_q.compare_two_pin_enable;

	assign st = '{f_cap1_q, f_cmp1_q, f_ovf_q, f_cap2_q, f_cmp2_q, 3'h0};

	assign irq_src = (c1_q.capture_irq_enable && (f_cap1_q || f_cap2_q))
		|| (c1_q.compare_irq_enable && (f_cmp1_q || f_cmp2_q))
		|| (c1_q.overflow_irq_enable && f_ovf_q);
	assign timer_irq   = irq_src && !cpu_irq_mask;
	assign wait_wakeup = timer_irq && in_wait_mode && !in_halt_mode;

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 8'h00;
		else if (bus_req.rd)
		begin
			case (bus_req.addr)
				A_CTRL_ONE: rdata_q <= c1_q;
				A_CTRL_TWO: rdata_q <= c2_q;
				A_STATUS:   rdata_q <= st;
				A_CAP1_HI:  rdata_q <= cap1_q[15:8];
				A_CAP1_LO:  rdata_q <= cap1_q[7:0];
				A_CAP2_HI:  rdata_q <= cap2_q[15:8];
				A_CAP2_LO:  rdata_q <= cap2_q[7:0];
				A_CMP1_HI:  rdata_q <= cmp1_q[15:8];
				A_CMP1_LO:  rdata_q <= cmp1_q[7:0];
				A_CMP2_HI:  rdata_q <= cmp2_q[15:8];
				A_CMP2_LO:  rdata_q <= cmp2_q[7:0];
				A_CNT_HI:   rdata_q <= cnt_q[15:8];
				A_CNT_LO:   rdata_q <= cnt_q[7:0];
				A_ACNT_HI:  rdata_q <= cnt_q[15:8];
				A_ACNT_LO:  rdata_q <= cnt_q[7:0];
				default:    rdata_q <= 8'h00;
			endcase
		end
		else
			rdata_q <= 8'h00;
	end
	assign rdata = rdata_q;

	a_irq_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
		(cpu_irq_mask || st[7:3] == 5'h00) |-> !timer_irq)
		else $error("irq gating wrong");
	a_halt_nowake: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_halt_mode |-> !wait_wakeup) else $error("woke from halt");
	a_cap_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
		(f_cap2_q && c1_q.capture_irq_enable && !cpu_irq_mask) |-> timer_irq)
		else $error("capture irq missing");
	a_cmp_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
		(f_cmp1_q && c1_q.compare_irq_enable && !cpu_irq_mask) |-> timer_irq)
		else $error("compare irq missing");
	a_ovf_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tick && cnt_q == CNT_MAX && !cnt_reload && !wr_cnt) |=> f_ovf_q && cnt_q == 16'h0000)
		else $error("overflow not flagged");
	a_pwm_reload: assert property (@(posedge clk_sys) disable iff (!nrst)
		(pwm_on && match2 && !wr_cnt) |=> cnt_q == CNT_RESET && f_cap1_q)
		else $error("pwm reload missed");
	a_cap1_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
		(cap1_edge && !pwm_on && !opm_on) |=> cap1_q == $past(cnt_q) && f_cap1_q)
		else $error("capture one not latched");
	a_status_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
		$past(bus_req.rd && bus_req.addr == A_STATUS) |-> rdata[2:0] == 3'b000)
		else $error("reserved status bits set");
	a_cmp1_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
		(match1 && !pwm_on && !opm_on) |=> pin1_q == $past(c1_q.output_level_one))
		else $error("compare one level wrong");
	a_cmp2_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
		(match2 && !pwm_on && !opm_on) |=> pin2_q == $past(c1_q.output_level_two))
		else $error("compare two level wrong");
	a_alternate_counter_low_byte_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
		(f_ovf_q && st_read_q && bus_req.rd && bus_req.addr == A_ACNT_LO) |=> f_ovf_q)
		else $error("alternate counter cleared overflow");
endmodule : timer16_capture_compare_ctrl

// ### dv/pin_model.sv
// far-side model: drives the capture and external count clock pins
`timescale 1ns/1ps
module pin_model (
	input  wire logic       clk_sys,
	input  wire logic [2:0] flip,
	output logic            capture_one_pin,
	output logic            capture_two_pin,
	output logic            external_count_clock_pin
);
	// levels hold between commands so each edge is seen exactly once
	initial
	begin
		{external_count_clock_pin, capture_two_pin, capture_one_pin} = 3'h0;
		forever @(posedge clk_sys)
			{external_count_clock_pin, capture_two_pin, capture_one_pin} <=
				{external_count_clock_pin, capture_two_pin, capture_one_pin} ^ flip;
	end
endmodule : pin_model

// ### dv/tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module tb
	import tmr_pkg::*;
;
	logic       clk_sys;
	logic       nrst;
	bus_req_s   bus_req;
	logic [7:0] rdata;
	logic       cpu_irq_mask;
	logic       in_wait_mode;
	logic       in_halt_mode;
	logic       capture_one_pin;
	logic       capture_two_pin;
	logic       external_count_clock_pin;
	logic       compare_one_pin;
	logic       compare_one_pin_oe;
	logic       compare_two_pin;
	logic       compare_two_pin_oe;
	logic       timer_irq;
	logic       wait_wakeup;
	logic [2:0] flip;
	logic [7:0] d;
	logic [7:0] rdata_nx;
	int         errors;
	int         checks;
	logic [1:0] sel_tab [3] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8};
	int         div_tab [3] = '{2, 4, 8};

	timer16_capture_compare_ctrl DUT (.clk_sys, .nrst, .bus_req, .rdata, .cpu_irq_mask,
		.in_wait_mode, .in_halt_mode, .capture_one_pin, .capture_two_pin,
		.external_count_clock_pin, .compare_one_pin, .compare_one_pin_oe, .compare_two_pin,
		.compare_two_pin_oe, .timer_irq, .wait_wakeup);
	pin_model far_pins (.clk_sys, .flip, .capture_one_pin, .capture_two_pin,
		.external_count_clock_pin);
	// twin without an external clock pin, sharing the same bus and pins
	timer16_capture_compare_ctrl #(.HAS_EXT_CLK(1'b0)) no_ext (.clk_sys, .nrst, .bus_req,
		.rdata(rdata_nx), .cpu_irq_mask, .in_wait_mode, .in_halt_mode, .capture_one_pin,
		.capture_two_pin, .external_count_clock_pin, .compare_one_pin(),
		.compare_one_pin_oe(), .compare_two_pin(), .compare_two_pin_oe(), .timer_irq(),
		.wait_wakeup());

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic bchk(input string n, input logic e, input logic g);
		chk(n, {7'h00, e}, {7'h00, g});
	endtask : bchk

	task automatic settle();
		@(posedge clk_sys);
		#1;
	endtask : settle

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		@(posedge clk_sys);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic rchk(input string n, input logic [4:0] a, input logic [7:0] e);
		rd(a);
		chk(n, e, d);
	endtask : rchk

	// one pin edge, then idle so the design sees a clean level
	task automatic tog(input int i);
		@(posedge clk_sys);
		flip <= 3'(1 << i);
		@(posedge clk_sys);
		flip <= 3'h0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : tog

	task automatic pulse();
		tog(2);
		tog(2);
	endtask : pulse

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		give_verdict();
	end

	initial
	begin
		errors = 0;
		checks = 0;
		bus_req = '0;
		flip = 3'h0;
		cpu_irq_mask = 1'b0;
		in_wait_mode = 1'b0;
		in_halt_mode = 1'b0;
		nrst = 1'b0;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		rchk("ctrl1", A_CTRL_ONE, 8'h00);
		rchk("ctrl2", A_CTRL_TWO, 8'h00);
		rchk("status", A_STATUS, 8'h00);
		rchk("cnt hi", A_CNT_HI, 8'hFF);
		rchk("unmapped", 5'h10, 8'h00);
		wr(A_CTRL_ONE, 8'hA5);
		rchk("ctrl1 rw", A_CTRL_ONE, 8'hA5);
		wr(A_CTRL_ONE, 8'h00);
		// the default divider wraps once soon after reset; clear that first
		repeat (20) @(posedge clk_sys);
		rd(A_STATUS);
		rd(A_CNT_LO);
		for (int i = 0; i < 3; i++)
		begin
			wr(A_CTRL_TWO, {4'h0, sel_tab[i], 2'b00});
			wr(A_CNT_LO, 8'h00);
			repeat (div_tab[i]) @(posedge clk_sys);
			rchk("ovf early", A_STATUS, 8'h00);
			repeat (5 * div_tab[i] + 4) @(posedge clk_sys);
			rchk("ovf", A_STATUS, 8'h20);
			rd(A_ACNT_LO);
			rchk("ovf alt", A_STATUS, 8'h20);
			rd(A_CNT_LO);
			rchk("ovf clr", A_STATUS, 8'h00);
		end
		wr(A_CTRL_TWO, 8'h04);
		wr(A_CNT_LO, 8'h00);
		repeat (20) @(posedge clk_sys);
		#1;
		bchk("irq off", 1'b0, timer_irq);
		wr(A_CTRL_ONE, 8'h20);
		settle();
		bchk("irq", 1'b1, timer_irq);
		in_wait_mode <= 1'b1;
		settle();
		bchk("wake", 1'b1, wait_wakeup);
		in_halt_mode <= 1'b1;
		settle();
		bchk("halt", 1'b0, wait_wakeup);
		in_halt_mode <= 1'b0;
		cpu_irq_mask <= 1'b1;
		settle();
		bchk("mask", 1'b0, timer_irq);
		cpu_irq_mask <= 1'b0;
		in_wait_mode <= 1'b0;
		wr(A_CTRL_ONE, 8'h00);
		rd(A_STATUS);
		rd(A_CNT_LO);
		// counting now only on the external pin, so values are exact
		wr(A_CTRL_TWO, 8'h0D);
		wr(A_CNT_LO, 8'h00);
		repeat (4) pulse();
		rchk("ext ovf", A_STATUS, 8'h20);
		rchk("ext hi", A_CNT_HI, 8'h00);
		rchk("ext lo", A_CNT_LO, 8'h00);
		chk("no ext", 8'hFC, rdata_nx);
		wr(A_CTRL_TWO, 8'h0C);
		tog(2);
		rchk("ext rise", A_CNT_LO, 8'h00);
		tog(2);
		rchk("ext fall", A_CNT_LO, 8'h01);
		rd(A_STATUS);
		rd(A_CNT_LO);
		wr(A_CTRL_ONE, 8'h80);
		tog(0);
		rchk("cap1 rise", A_STATUS, 8'h00);
		tog(0);
		rchk("cap1", A_STATUS, 8'h80);
		bchk("cap irq", 1'b1, timer_irq);
		rchk("cap1 hi", A_CAP1_HI, 8'h00);
		rchk("cap1 lo", A_CAP1_LO, 8'h01);
		rchk("cap1 kept", A_STATUS, 8'h80);
		rd(A_CAP1_LO);
		rchk("cap1 clr", A_STATUS, 8'h00);
		wr(A_CTRL_TWO, 8'h0E);
		tog(1);
		rchk("cap2", A_STATUS, 8'h10);
		bchk("cap2 irq", 1'b1, timer_irq);
		rd(A_CAP2_LO);
		rchk("cap2 clr", A_STATUS, 8'h00);
		wr(A_CTRL_TWO, 8'h8D);
		wr(A_CTRL_ONE, 8'h41);
		wr(A_CNT_LO, 8'h00);
		wr(A_CMP1_HI, 8'hFF);
		wr(A_CMP1_LO, 8'hFC);
		wr(A_CMP2_HI, 8'hFF);
		wr(A_CMP2_LO, 8'hFC);
		pulse();
		rchk("cmp flags", A_STATUS, 8'h48);
		bchk("pin1", 1'b1, compare_one_pin);
		bchk("oe2", 1'b0, compare_two_pin_oe);
		bchk("oe1", 1'b1, compare_one_pin_oe);
		bchk("cmp irq", 1'b1, timer_irq);
		rd(A_CMP1_LO);
		rchk("cmp1 clr", A_STATUS, 8'h08);
		rd(A_CMP2_LO);
		rchk("cmp2 clr", A_STATUS, 8'h00);
		wr(A_CTRL_TWO, 8'hCD);
		wr(A_CTRL_ONE, 8'h14);
		settle();
		bchk("force2", 1'b1, compare_two_pin);
		wr(A_CTRL_ONE, 8'h08);
		settle();
		bchk("force1", 1'b0, compare_one_pin);
		wr(A_CTRL_ONE, 8'h01);
		wr(A_CMP1_HI, 8'hFF);
		wr(A_CMP1_LO, 8'hFD);
		wr(A_CMP2_HI, 8'hFF);
		wr(A_CMP2_LO, 8'hFE);
		wr(A_CTRL_TWO, 8'h9D);
		wr(A_CNT_LO, 8'h00);
		pulse();
		pulse();
		bchk("pwm width", 1'b1, compare_one_pin);
		pulse();
		bchk("pwm period", 1'b0, compare_one_pin);
		rchk("pwm flag", A_STATUS, 8'h80);
		rchk("pwm reload", A_CNT_LO, 8'hFC);
		rd(A_STATUS);
		rd(A_CAP1_LO);
		// one-pulse: rising capture one starts it, compare one ends it
		wr(A_CTRL_ONE, 8'h06);
		wr(A_CTRL_TWO, 8'hAD);
		tog(0);
		bchk("opm start", 1'b1, compare_one_pin);
		pulse();
		bchk("opm width", 1'b1, compare_one_pin);
		pulse();
		bchk("opm end", 1'b0, compare_one_pin);
		rchk("opm flags", A_STATUS, 8'h80);
		give_verdict();
	end
endmodule : tb
